// ===== pkg/pmc_pkg.sv
// package: offsets, field layout, fixed values and carriers of the power-management capability
`default_nettype none
package pmc_pkg;
    // configuration offsets, relative to the capability base
    localparam logic [2:0]  PMC_OFF_CAPS     = 3'h2;
    localparam logic [2:0]  PMC_OFF_CTRL     = 3'h4;
    // capabilities word field positions
    localparam int          CAP_D3COLD_BIT   = 15;
    localparam int          CAP_D3HOT_BIT    = 14;
    localparam int          CAP_D2WAKE_BIT   = 13;
    localparam int          CAP_D1WAKE_BIT   = 12;
    localparam int          CAP_D0WAKE_BIT   = 11;
    localparam int          CAP_STATE2_BIT   = 10;
    localparam int          CAP_STATE1_BIT   = 9;
    localparam int          CAP_AUX_LSB      = 6;
    localparam int          CAP_AUX_MSB      = 8;
    localparam int          CAP_DSI_BIT      = 5;
    localparam int          CAP_WAKECLK_BIT  = 3;
    localparam int          CAP_VER_LSB      = 0;
    localparam int          CAP_VER_MSB      = 2;
    // fixed capability values
    localparam logic        CAP_D3HOT_VAL    = 1'b1;
    localparam logic        CAP_NO_VAL       = 1'b0;
    // control/status word field positions
    localparam int          CTL_STATUS_BIT   = 15;
    localparam int          CTL_ENABLE_BIT   = 8;
    localparam int          CTL_PSTATE_LSB   = 0;
    localparam int          CTL_PSTATE_MSB   = 1;
    localparam int          BE_HIGH          = 1;
    localparam int          BE_LOW           = 0;
    // power-state codes and reset values
    typedef logic [1:0] pmc_pstate_t;
    localparam pmc_pstate_t PMC_PSTATE_D0    = 2'h0;
    localparam pmc_pstate_t PMC_PSTATE_D3HOT = 2'h3;
    localparam pmc_pstate_t PMC_PSTATE_RESET = 2'h0;
    localparam logic        STATUS_RESET     = 1'b0;
    localparam logic        ENABLE_RESET     = 1'b0;
    localparam logic [15:0] RDATA_RESET      = 16'h0000;
    // one configuration request per cycle
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [2:0]  addr;
        logic [1:0]  be;
        logic [15:0] wdata;
    } pmc_cfg_req_s;
endpackage : pmc_pkg
`default_nettype wire

// ===== rtl/pmc_power_state.sv
// power-state field: holds the current state and filters requested codes
`default_nettype none
module pmc_power_state (
    input  wire logic                 ref_clk,
    input  wire logic                 rst_b,
    input  wire logic                 pstate_wr,
    input  wire pmc_pkg::pmc_pstate_t pstate_wdata,
    output var  pmc_pkg::pmc_pstate_t pstate_reg,
    output wire logic                 d3hot
);
    logic pstate_legal;

    // only d0 and d3hot are kept; d1/d2 codes leave the state alone
    assign pstate_legal = (pstate_wdata == pmc_pkg::PMC_PSTATE_D0) ||
                          (pstate_wdata == pmc_pkg::PMC_PSTATE_D3HOT);

    // state register, comes up in d0
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pstate_reg <= pmc_pkg::PMC_PSTATE_RESET;
        end else if (pstate_wr && pstate_legal) begin
            pstate_reg <= pstate_wdata;
        end
    end

    assign d3hot = (pstate_reg == pmc_pkg::PMC_PSTATE_D3HOT);

    AST_ILLEGAL_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_b)
        pstate_wr && !pstate_legal |=> pstate_reg == $past(pstate_reg))
        else $error("unsupported power-state code changed the state");
    AST_LEGAL_CODE: assert property (@(posedge ref_clk) disable iff (!rst_b)
        pstate_reg == pmc_pkg::PMC_PSTATE_D0 || pstate_reg == pmc_pkg::PMC_PSTATE_D3HOT)
        else $error("power state holds an unsupported code");
endmodule : pmc_power_state
`default_nettype wire

// ===== rtl/pmc_capability.sv
// power-management capability: capabilities word, control/status word and d3hot gating
`default_nettype none

module pmc_capability #(
    parameter logic       D3COLD_WAKE = 1'b0,
    parameter logic [2:0] AUX_CURRENT = 3'h0,
    parameter logic       DEV_INIT    = 1'b0,
    parameter logic [2:0] PM_VERSION  = 3'h2
) (
    input  wire logic                  ref_clk,
    input  wire logic                  rst_b,
    input  wire pmc_pkg::pmc_cfg_req_s cfg_req,
    output logic [15:0]                cfg_rdata,
    output logic                       cfg_ack,
    input  wire logic                  wake_event_req,
    output logic                       wake_event_b,
    input  wire logic                  irq_req,
    output logic                       irq_out,
    input  wire logic                  mem_req,
    output logic                       mem_grant,
    output logic                       d3hot_state
);
    logic                 cfg_hit_caps;
    logic                 cfg_hit_ctrl;
    logic                 status_set;
    logic                 status_clr;
    logic                 enable_wr;
    logic                 pstate_wr;
    logic                 d3hot;
    logic                 wake_event_status;
    logic                 wake_event_enable;
    pmc_pkg::pmc_pstate_t power_state_field;
    logic [15:0]          power_capabilities;
    logic [15:0]          power_control_status;
    logic [15:0]          rdata_next;

    // offset decode of the configuration request
    assign cfg_hit_caps = (cfg_req.addr == pmc_pkg::PMC_OFF_CAPS);
    assign cfg_hit_ctrl = (cfg_req.addr == pmc_pkg::PMC_OFF_CTRL);

    // capabilities word: all constant, built from parameters and fixed values
    always_comb begin
        power_capabilities = 16'h0000;
        power_capabilities[pmc_pkg::CAP_D3COLD_BIT] = D3COLD_WAKE;
        power_capabilities[pmc_pkg::CAP_D3HOT_BIT]  = pmc_pkg::CAP_D3HOT_VAL;
        power_capabilities[pmc_pkg::CAP_D2WAKE_BIT] = pmc_pkg::CAP_NO_VAL;
        power_capabilities[pmc_pkg::CAP_D1WAKE_BIT] = pmc_pkg::CAP_NO_VAL;
        power_capabilities[pmc_pkg::CAP_D0WAKE_BIT] = pmc_pkg::CAP_NO_VAL;
        power_capabilities[pmc_pkg::CAP_STATE2_BIT] = pmc_pkg::CAP_NO_VAL;
        power_capabilities[pmc_pkg::CAP_STATE1_BIT] = pmc_pkg::CAP_NO_VAL;
        power_capabilities[pmc_pkg::CAP_AUX_MSB:pmc_pkg::CAP_AUX_LSB] = AUX_CURRENT;
        power_capabilities[pmc_pkg::CAP_DSI_BIT]    = DEV_INIT;
        power_capabilities[pmc_pkg::CAP_WAKECLK_BIT] = pmc_pkg::CAP_NO_VAL;
        power_capabilities[pmc_pkg::CAP_VER_MSB:pmc_pkg::CAP_VER_LSB] = PM_VERSION;
    end

    // write strobes; the high byte lane carries status and enable
    assign status_clr = cfg_req.wr && cfg_hit_ctrl && cfg_req.be[pmc_pkg::BE_HIGH] &&
                        cfg_req.wdata[pmc_pkg::CTL_STATUS_BIT];
    assign enable_wr  = cfg_req.wr && cfg_hit_ctrl && cfg_req.be[pmc_pkg::BE_HIGH];
    assign pstate_wr  = cfg_req.wr && cfg_hit_ctrl && cfg_req.be[pmc_pkg::BE_LOW];

    // wake events are only raised out of d3hot; in d0 the core uses interrupts
    assign status_set = wake_event_req && d3hot;

    // power-state field lives in its own module
    pmc_power_state u_power_state (
        .ref_clk  (ref_clk),
        .rst_b    (rst_b),
        .pstate_wr    (pstate_wr),
        .pstate_wdata (cfg_req.wdata[pmc_pkg::CTL_PSTATE_MSB:pmc_pkg::CTL_PSTATE_LSB]),
        .pstate_reg   (power_state_field),
        .d3hot        (d3hot)
    );

    // wake status: set beats a simultaneous write-one clear so no event is lost
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wake_event_status <= pmc_pkg::STATUS_RESET;
        end else if (status_set) begin
            wake_event_status <= 1'b1;
        end else if (status_clr) begin
            wake_event_status <= 1'b0;
        end
    end

    // wake enable, plain read/write bit
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wake_event_enable <= pmc_pkg::ENABLE_RESET;
        end else if (enable_wr) begin
            wake_event_enable <= cfg_req.wdata[pmc_pkg::CTL_ENABLE_BIT];
        end
    end

    // control/status word; data-register bits and reserved bits read zero
    always_comb begin
        power_control_status = 16'h0000;
        power_control_status[pmc_pkg::CTL_STATUS_BIT] = wake_event_status;
        power_control_status[pmc_pkg::CTL_ENABLE_BIT] = wake_event_enable;
        power_control_status[pmc_pkg::CTL_PSTATE_MSB:pmc_pkg::CTL_PSTATE_LSB] = power_state_field;
    end

    // read mux; offsets outside this capability answer zero
    always_comb begin
        rdata_next = pmc_pkg::RDATA_RESET;
        if (cfg_hit_caps) begin
            rdata_next = power_capabilities;
        end else if (cfg_hit_ctrl) begin
            rdata_next = power_control_status;
        end
    end

    // configuration answer, one cycle after the request, in every power state
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_rdata <= pmc_pkg::RDATA_RESET;
            cfg_ack   <= 1'b0;
        end else begin
            cfg_ack   <= cfg_req.rd || cfg_req.wr;
            if (cfg_req.rd) begin
                cfg_rdata <= rdata_next;
            end
        end
    end

    // wake output, active low; registered so it never glitches on the pin
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wake_event_b <= 1'b1;
        end else begin
            wake_event_b <= !(wake_event_status && wake_event_enable);
        end
    end

    // d3hot gating of interrupts and memory-space accesses
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_out     <= 1'b0;
            mem_grant   <= 1'b0;
            d3hot_state <= 1'b0;
        end else begin
            irq_out     <= irq_req && !d3hot;
            mem_grant   <= mem_req && !d3hot;
            d3hot_state <= d3hot;
        end
    end

    // checks on the capabilities word, seen through a read
    AST_CAPS_STATE2: assert property (@(posedge ref_clk) disable iff (!rst_b)
        cfg_req.rd && cfg_hit_caps |=> !cfg_rdata[pmc_pkg::CAP_STATE2_BIT])
        else $error("capabilities advertise d2");
    AST_CAPS_STATE1: assert property (@(posedge ref_clk) disable iff (!rst_b)
        cfg_req.rd && cfg_hit_caps |=> !cfg_rdata[pmc_pkg::CAP_STATE1_BIT])
        else $error("capabilities advertise d1");
    AST_CAPS_D1WAKE: assert property (@(posedge ref_clk) disable iff (!rst_b)
        cfg_req.rd && cfg_hit_caps |=> !cfg_rdata[pmc_pkg::CAP_D1WAKE_BIT])
        else $error("capabilities advertise wake from d1");
    AST_CAPS_D0WAKE: assert property (@(posedge ref_clk) disable iff (!rst_b)
        cfg_req.rd && cfg_hit_caps |=> !cfg_rdata[pmc_pkg::CAP_D0WAKE_BIT])
        else $error("capabilities advertise wake from d0");
    AST_CAPS_D3HOT: assert property (@(posedge ref_clk) disable iff (!rst_b)
        cfg_req.rd && cfg_hit_caps |=> cfg_rdata[pmc_pkg::CAP_D3HOT_BIT])
        else $error("capabilities hide wake from d3hot");
    AST_CAPS_WAKECLK: assert property (@(posedge ref_clk) disable iff (!rst_b)
        cfg_req.rd && cfg_hit_caps |=> !cfg_rdata[pmc_pkg::CAP_WAKECLK_BIT])
        else $error("capabilities claim wake needs the clock");
    AST_CAPS_FIXED: assert property (@(posedge ref_clk) disable iff (!rst_b)
        cfg_req.rd && cfg_hit_caps |=>
        cfg_rdata[pmc_pkg::CAP_AUX_MSB:pmc_pkg::CAP_AUX_LSB] == AUX_CURRENT &&
        cfg_rdata[pmc_pkg::CAP_DSI_BIT] == DEV_INIT &&
        cfg_rdata[pmc_pkg::CAP_VER_MSB:pmc_pkg::CAP_VER_LSB] == PM_VERSION)
        else $error("fixed capability fields differ from parameters");

    // checks on the control/status word
    AST_CTRL_ZERO: assert property (@(posedge ref_clk) disable iff (!rst_b)
        cfg_req.rd && cfg_hit_ctrl |=>
        cfg_rdata[pmc_pkg::CTL_STATUS_BIT-1:pmc_pkg::CTL_ENABLE_BIT+1] == '0 &&
        cfg_rdata[pmc_pkg::CTL_ENABLE_BIT-1:pmc_pkg::CTL_PSTATE_MSB+1] == '0)
        else $error("reserved control bits read non-zero");
    AST_STATUS_SET: assert property (@(posedge ref_clk) disable iff (!rst_b)
        wake_event_req && d3hot |=> wake_event_status)
        else $error("wake event did not set status");
    AST_STATUS_CLR: assert property (@(posedge ref_clk) disable iff (!rst_b)
        status_clr && !status_set |=> !wake_event_status)
        else $error("write one did not clear status");
    AST_STATUS_D0: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !wake_event_status && !d3hot |=> !wake_event_status)
        else $error("status rose while in d0");
    AST_WAKE_OUT: assert property (@(posedge ref_clk) disable iff (!rst_b)
        wake_event_status && wake_event_enable |=> !wake_event_b)
        else $error("enabled status did not drive the wake output");
    AST_WAKE_QUIET: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !wake_event_enable |=> wake_event_b)
        else $error("wake output active while disabled");
    AST_PSTATE_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_b)
        pstate_wr && cfg_req.wdata[pmc_pkg::CTL_PSTATE_MSB:pmc_pkg::CTL_PSTATE_LSB] ==
        pmc_pkg::PMC_PSTATE_D3HOT |=> power_state_field == pmc_pkg::PMC_PSTATE_D3HOT)
        else $error("power state write did not take effect");
    AST_MEM_BLOCK: assert property (@(posedge ref_clk) disable iff (!rst_b)
        d3hot |=> !mem_grant)
        else $error("memory access granted in d3hot");
    AST_CFG_ALIVE: assert property (@(posedge ref_clk) disable iff (!rst_b)
        d3hot && cfg_req.rd |=> cfg_ack)
        else $error("configuration read unanswered in d3hot");
    AST_IRQ_BLOCK: assert property (@(posedge ref_clk) disable iff (!rst_b)
        d3hot |=> !irq_out)
        else $error("interrupt delivered in d3hot");
    AST_IRQ_PASS: assert property (@(posedge ref_clk) disable iff (!rst_b)
        irq_req && !d3hot |=> irq_out)
        else $error("interrupt lost in d0");
    AST_RESET_VALUES: assert property (@(posedge ref_clk)
        $rose(rst_b) |-> !wake_event_status && !wake_event_enable &&
        power_state_field == pmc_pkg::PMC_PSTATE_D0)
        else $error("control bits not at reset values");

    // main scenarios
    COV_ENTER_D3HOT: cover property (@(posedge ref_clk) disable iff (!rst_b)
        $rose(d3hot));
    COV_WAKE: cover property (@(posedge ref_clk) disable iff (!rst_b)
        $fell(wake_event_b));
    COV_SET_AND_CLR: cover property (@(posedge ref_clk) disable iff (!rst_b)
        status_set && status_clr);
    COV_BACK_TO_D0: cover property (@(posedge ref_clk) disable iff (!rst_b)
        $fell(d3hot));
endmodule : pmc_capability
`default_nettype wire

// ===== tb/pmc_host_model.sv
// host model: issues configuration reads and writes to the capability
`default_nettype none
module pmc_host_model (
    input  wire logic                  ref_clk,
    output var  pmc_pkg::pmc_cfg_req_s cfg_req,
    input  wire logic [15:0]           cfg_rdata,
    input  wire logic                  cfg_ack
);
    timeunit 1ns;
    timeprecision 1ps;

    initial cfg_req = '{rd: 1'b0, wr: 1'b0, addr: 3'h7, be: 2'h0, wdata: 16'h5a5a};

    // one strobe pulse, then a bounded wait for the acknowledge
    task automatic access(
        input  logic        rd,
        input  logic        wr,
        input  logic [2:0]  addr,
        input  logic [1:0]  be,
        input  logic [15:0] wdata,
        output logic [15:0] rdata
    );
        int n;
        rdata = 16'hxxxx; // a missing acknowledge shows up as unknown data
        @(posedge ref_clk);
        cfg_req <= '{rd: rd, wr: wr, addr: addr, be: be, wdata: wdata};
        @(posedge ref_clk);
        // released lines flip, so a design sampling stale values is caught
        cfg_req <= '{rd: 1'b0, wr: 1'b0, addr: ~addr, be: ~be, wdata: ~wdata};
        for (n = 0; n < 4; n++) begin
            @(posedge ref_clk);
            if (cfg_ack === 1'b1) begin
                rdata = cfg_rdata;
                break;
            end
        end
    endtask : access
endmodule : pmc_host_model
`default_nettype wire

// ===== tb/pci_power_mgmt_capability_bench.sv
// self-checking bench for the power-management capability
`default_nettype none
module pci_power_mgmt_capability_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [2:0]  AUX  = 3'h5;
    localparam logic [2:0]  VER  = 3'h3;
    localparam logic [2:0]  CTRL = pmc_pkg::PMC_OFF_CTRL;
    // caps word built from the instance parameters, non-default values except D3COLD_WAKE to see fields move
    localparam logic [15:0] CAPS = {1'b0, 1'b1, 3'h0, 2'h0, AUX, 1'b1, 1'b0, 1'b0, VER};

    logic                  ref_clk;
    logic                  rst_b;
    pmc_pkg::pmc_cfg_req_s cfg_req;
    logic [15:0]           cfg_rdata;
    logic                  cfg_ack;
    logic                  wake_event_req;
    logic                  wake_event_b;
    logic                  irq_req;
    logic                  irq_out;
    logic                  mem_req;
    logic                  mem_grant;
    logic                  d3hot_state;
    int                    num_errors;
    int                    tests_run;
    int                    cycles;

    pmc_capability #(.D3COLD_WAKE(1'b0), .AUX_CURRENT(AUX), .DEV_INIT(1'b1),
                     .PM_VERSION(VER)) DUT (
        .ref_clk(ref_clk), .rst_b(rst_b), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
        .cfg_ack(cfg_ack), .wake_event_req(wake_event_req), .wake_event_b(wake_event_b),
        .irq_req(irq_req), .irq_out(irq_out), .mem_req(mem_req), .mem_grant(mem_grant),
        .d3hot_state(d3hot_state)
    );

    pmc_host_model host (
        .ref_clk(ref_clk), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack)
    );

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic edges(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : edges

    task automatic rdchk(input logic [2:0] a, input logic [15:0] exp);
        logic [15:0] d;
        host.access(1'b1, 1'b0, a, 2'h3, 16'h0000, d);
        check(d, exp);
    endtask : rdchk

    task automatic wr(input logic [2:0] a, input logic [1:0] be, input logic [15:0] d);
        logic [15:0] unused;
        host.access(1'b0, 1'b1, a, be, d, unused);
    endtask : wr

    // one wake request, sampled at a single edge
    task automatic wake_pulse();
        wake_event_req <= 1'b1;
        edges(1);
        wake_event_req <= 1'b0;
        edges(3);
    endtask : wake_pulse

    task automatic complete_run();
        if (num_errors == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run

    // hang guard: the sequence needs about a hundred cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 2000) begin
            num_errors++;
            complete_run();
        end
    end

    initial begin
        num_errors = 0;
        tests_run = 0;
        cycles = 0;
        rst_b = 1'b0;
        wake_event_req = 1'b0;
        irq_req = 1'b0;
        mem_req = 1'b0;
        edges(12);
        rst_b <= 1'b1;
        // reset values and fixed capability fields
        rdchk(pmc_pkg::PMC_OFF_CAPS, CAPS);
        rdchk(CTRL, 16'h0000);
        check(wake_event_b, 1'b1);
        // capabilities word ignores writes; a write to unmapped offset 6 leaves unmapped offset 0 reading zero
        wr(pmc_pkg::PMC_OFF_CAPS, 2'h3, ~CAPS);
        rdchk(pmc_pkg::PMC_OFF_CAPS, CAPS);
        wr(3'h6, 2'h3, 16'hffff);
        rdchk(3'h0, 16'h0000);
        // set enable; reserved bits written as ones still read zero
        wr(CTRL, 2'h3, 16'h7ffc);
        rdchk(CTRL, 16'h0100);
        irq_req <= 1'b1;
        mem_req <= 1'b1;
        edges(3);
        check(irq_out, 1'b1);
        check(mem_grant, 1'b1);
        // unsupported codes, and a write missing the low lane, keep d0
        for (int c = 1; c < 3; c++) begin
            wr(CTRL, 2'h1, 16'(c));
            rdchk(CTRL, 16'h0100);
        end
        wr(CTRL, 2'h2, 16'h0103);
        rdchk(CTRL, 16'h0100);
        // enter d3hot: config still answers, interrupts and memory blocked
        wr(CTRL, 2'h1, {14'h0000, pmc_pkg::PMC_PSTATE_D3HOT});
        edges(2);
        check(d3hot_state, 1'b1);
        check(irq_out, 1'b0);
        check(mem_grant, 1'b0);
        rdchk(CTRL, 16'h0103);
        // wake with enable set, then write one to clear
        wake_pulse();
        check(wake_event_b, 1'b0);
        rdchk(CTRL, 16'h8103);
        wr(CTRL, 2'h2, 16'h8100);
        rdchk(CTRL, 16'h0103);
        check(wake_event_b, 1'b1);
        // wake with enable clear: status sets, wake line stays high
        wr(CTRL, 2'h2, 16'h0000);
        wake_pulse();
        check(wake_event_b, 1'b1);
        rdchk(CTRL, 16'h8003);
        // back to d0 releases the gating
        wr(CTRL, 2'h1, {14'h0000, pmc_pkg::PMC_PSTATE_D0});
        edges(2);
        check(d3hot_state, 1'b0);
        check(mem_grant, 1'b1);
        // reset in mid-run clears the pending status
        wr(CTRL, 2'h1, 16'h0003);
        rst_b <= 1'b0;
        edges(2);
        check(d3hot_state, 1'b0);
        rst_b <= 1'b1;
        rdchk(CTRL, 16'h0000);
        check(irq_out, 1'b1);
        complete_run();
    end
endmodule : pci_power_mgmt_capability_bench
`default_nettype wire
